//--- design/wsd_consts.vh
// constants for the waveform steering, shutdown and dead-band generator
`ifndef WSD_CONSTS_VH
`define WSD_CONSTS_VH

// ==========================================================
// register indices (byte address is four times the index)
`define WSD_IDX_CLKSEL     12'h60c
`define WSD_IDX_INSEL      12'h60d
`define WSD_IDX_DBRISE     12'h60e
`define WSD_IDX_DBFALL     12'h60f
`define WSD_IDX_CTRL0      12'h610
`define WSD_IDX_CTRL1      12'h611
`define WSD_IDX_SDCTRL     12'h612
`define WSD_IDX_SDSRC      12'h613
`define WSD_IDX_STEER      12'h614
`define WSD_IDX_IRQSTAT    12'h615
`define WSD_IDX_IRQMASK    12'h616

// ==========================================================
// field positions
`define WSD_CTRL0_EN       7
`define WSD_CTRL0_LD       6
`define WSD_CTRL1_IN       5
`define WSD_SD_STATUS      7
`define WSD_SD_REN         6

// ==========================================================
// mode codes
`define WSD_MODE_ASTEER    3'h0
`define WSD_MODE_SSTEER    3'h1
`define WSD_MODE_FWDFB     3'h2
`define WSD_MODE_REVFB     3'h3
`define WSD_MODE_HALFB     3'h4
`define WSD_MODE_PUSHP     3'h5

// ==========================================================
// shutdown level codes
`define WSD_SDL_INACT      2'h0
`define WSD_SDL_TRI        2'h1
`define WSD_SDL_LOW        2'h2
`define WSD_SDL_HIGH       2'h3

// ==========================================================
// reset values
`define WSD_RST_STEER      8'h00
`define WSD_RST_SDCTRL     8'h14
`define WSD_RST_ZERO       8'h00

// ==========================================================
// data input source range limits
`define WSD_ISM_LOWTOP     5'h06
`define WSD_ISM_HIBOT      5'h0b
`define WSD_ISM_HITOP      5'h11

`endif

//--- design/wsd_generator.v
// output stage: steering, bridge modes, dead band, auto-shutdown, wishbone registers
`timescale 1ns/1ps
`include "wsd_consts.vh"

// Contract
// (RULE1) steer enabled: output follows input with polarity
// (RULE2) steer disabled: output equals override bit
// (RULE3) steer bits act only in steering modes
// (RULE4) synchronous steering double-buffers steer enables
// (RULE5) shutdown status bit reflects shutdown state
// (RULE6) software shutdown write forces shutdown levels
// (RULE7) after clear, hold until input rising edge
// (RULE8) auto-restart enable bit controls restart
// (RULE9) B/D shutdown level by two-bit field
// (RULE10) A/C shutdown level by two-bit field
// (RULE11) eight shutdown source enable bits
// (RULE12) rising dead band n cycles, zero bypasses
// (RULE13) falling dead band n cycles, zero bypasses
// (RULE14) dead-band counts untouched by reset
// (RULE15) three-bit mode field selects operation
// (RULE16) per-output polarity bit inverts output
// (RULE17) clock select bit chooses generator clock
// (RULE18) enabled active source sets shutdown status
// (RULE19) auto-restart clears status when sources idle
module wsd_generator (
   // clock and reset
   input  wire        clk_sys,
   input  wire        reset,
   // wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [13:0] wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // waveform and shutdown sources (asynchronous)
   input  wire [17:0] dataSources,
   input  wire [7:0]  shutdownSources,
   // output pins a..d, bit 0 is a
   output reg  [3:0]  pinOut_q,
   output reg  [3:0]  pinOe_q,
   // clock source choice and interrupt
   output reg         fastOscSelect_q,
   output reg         irq_q
);

   // ==========================================================
   // decoding helpers
   // shutdown level to {drive enable, level}
   function [1:0] sdLevel;
      input [1:0] code;
      input       pol;
      begin
         case (code)
            `WSD_SDL_HIGH: sdLevel = 2'b11;
            `WSD_SDL_LOW:  sdLevel = 2'b10;
            `WSD_SDL_TRI:  sdLevel = 2'b00;
            default:       sdLevel = {1'b1, pol};
         endcase
      end
   endfunction

   // ==========================================================
   // registers
   // reset images, sliced per field so no bits are dropped silently
   localparam [7:0] RST_SD  = `WSD_RST_SDCTRL;
   localparam [7:0] RST_STR = `WSD_RST_STEER;
   reg  [7:0]  inSel_q;
   reg  [5:0]  dbRise_q;
   reg  [5:0]  dbFall_q;
   reg         enable_q;
   reg         loadReq_q;
   reg  [2:0]  mode_q;
   reg  [3:0]  polarity_q;
   reg         shutdown_q;
   reg         restartEn_q;
   reg  [1:0]  pairBdLevel_q;
   reg  [1:0]  pairAcLevel_q;
   reg  [7:0]  sdEnable_q;
   reg  [3:0]  overrideLevel_q;
   reg  [3:0]  steerWritten_q;
   reg  [3:0]  steerActive_q;
   reg  [1:0]  irqStatus_q;
   reg  [1:0]  irqMask_q;
   reg         holdShut_q;
   reg         effShutPrev_q;

   // ==========================================================
   // bus decode
   wire        busReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire [11:0] regIdx   = wb_adr_i[13:2];
   wire        wrLow    = busReq & wb_we_i & wb_sel_i[0];
   wire [7:0]  wd       = wb_dat_i[7:0];

   // ==========================================================
   // input synchronisers, three stages, change accepted when stages 2 and 3 agree
   reg  [8:0]  sync1_q;
   reg  [8:0]  sync2_q;
   reg  [8:0]  sync3_q;
   reg  [8:0]  syncFilt_q;
   wire [4:0]  data_input_source      = inSel_q[4:0];
   wire        ismOk    = (data_input_source <= `WSD_ISM_LOWTOP) |
                          ((data_input_source >= `WSD_ISM_HIBOT) & (data_input_source <= `WSD_ISM_HITOP));
   wire        rawData  = ismOk ? dataSources[data_input_source] : 1'b0;
   integer k;

   // sample selected data input and shutdown sources
   always @(posedge clk_sys) begin
      if (reset) begin
         sync1_q    <= 9'h000;
         sync2_q    <= 9'h000;
         sync3_q    <= 9'h000;
         syncFilt_q <= 9'h000;
      end else begin
         sync1_q <= {rawData, shutdownSources};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         for (k = 0; k < 9; k = k + 1) begin
            if (sync2_q[k] == sync3_q[k]) begin
               syncFilt_q[k] <= sync3_q[k];
            end
         end
      end
   end

   wire        dataIn   = syncFilt_q[8];
   reg         dataPrev_q;
   wire        dataRise = dataIn & ~dataPrev_q;
   wire        dataFall = ~dataIn & dataPrev_q;
   wire        srcHit   = |(syncFilt_q[7:0] & sdEnable_q); // RULE11
   wire        effShut  = shutdown_q | holdShut_q;

   // ==========================================================
   // dead-band counters
   reg  [5:0]  riseCnt_q;
   reg  [5:0]  fallCnt_q;
   wire        riseLoad = dataRise & (dbRise_q != 6'h00);
   wire        fallLoad = dataFall & (dbFall_q != 6'h00);
   wire        riseDrv  = dataIn & (riseCnt_q == 6'h00) & ~riseLoad;   // RULE12
   wire        fallDrv  = ~dataIn & (fallCnt_q == 6'h00) & ~fallLoad;  // RULE13

   // count out the hold-off after each input edge
   always @(posedge clk_sys) begin
      if (reset) begin
         riseCnt_q  <= 6'h00;
         fallCnt_q  <= 6'h00;
         dataPrev_q <= 1'b0;
      end else begin
         dataPrev_q <= dataIn;
         if (riseLoad) begin
            riseCnt_q <= dbRise_q; // RULE12
         end else if (riseCnt_q != 6'h00) begin
            riseCnt_q <= riseCnt_q - 6'h01;
         end
         if (fallLoad) begin
            fallCnt_q <= dbFall_q; // RULE13
         end else if (fallCnt_q != 6'h00) begin
            fallCnt_q <= fallCnt_q - 6'h01;
         end
      end
   end

   // ==========================================================
   // dead-band counts hold their value through reset
   always @(posedge clk_sys) begin
      if (wrLow & (regIdx == `WSD_IDX_DBRISE)) begin
         dbRise_q <= wd[5:0]; // RULE14
      end
      if (wrLow & (regIdx == `WSD_IDX_DBFALL)) begin
         dbFall_q <= wd[5:0]; // RULE14
      end
   end

   // ==========================================================
   // configuration and status registers
   wire        sdWrite  = wrLow & (regIdx == `WSD_IDX_SDCTRL);
   wire        autoClr  = restartEn_q & ~srcHit;
   always @(posedge clk_sys) begin
      if (reset) begin
         inSel_q         <= `WSD_RST_ZERO;
         enable_q        <= 1'b0;
         loadReq_q       <= 1'b0;
         mode_q          <= 3'h0;
         polarity_q      <= 4'h0;
         shutdown_q      <= 1'b0;
         restartEn_q     <= 1'b0;
         pairBdLevel_q   <= RST_SD[5:4];
         pairAcLevel_q   <= RST_SD[3:2];
         sdEnable_q      <= `WSD_RST_ZERO;
         overrideLevel_q <= RST_STR[7:4];
         steerWritten_q  <= 4'h0;
         irqMask_q       <= 2'h0;
         fastOscSelect_q <= 1'b0;
      end else begin
         if (wrLow & (regIdx == `WSD_IDX_CLKSEL)) begin
            fastOscSelect_q <= wd[0]; // RULE17
         end
         if (wrLow & (regIdx == `WSD_IDX_INSEL)) begin
            inSel_q <= {3'h0, wd[4:0]};
         end
         if (wrLow & (regIdx == `WSD_IDX_CTRL0)) begin
            enable_q <= wd[`WSD_CTRL0_EN];
            mode_q   <= wd[2:0]; // RULE15
         end
         // load request is taken only once the generator is enabled
         if (wrLow & (regIdx == `WSD_IDX_CTRL0) & enable_q & wd[`WSD_CTRL0_LD]) begin
            loadReq_q <= 1'b1;
         end else if (dataRise | ~enable_q) begin
            loadReq_q <= 1'b0;
         end
         if (wrLow & (regIdx == `WSD_IDX_CTRL1)) begin
            polarity_q <= wd[3:0]; // RULE16
         end
         if (sdWrite) begin
            restartEn_q   <= wd[`WSD_SD_REN]; // RULE8
            pairBdLevel_q <= wd[5:4];         // RULE9
            pairAcLevel_q <= wd[3:2];         // RULE10
         end
         // source hit while enabled wins over any clear
         if (enable_q & srcHit) begin
            shutdown_q <= 1'b1; // RULE18
         end else if (sdWrite) begin
            shutdown_q <= wd[`WSD_SD_STATUS]; // RULE5 RULE6
         end else if (shutdown_q & autoClr) begin
            shutdown_q <= 1'b0; // RULE19
         end
         if (wrLow & (regIdx == `WSD_IDX_SDSRC)) begin
            sdEnable_q <= wd; // RULE11
         end
         if (wrLow & (regIdx == `WSD_IDX_STEER)) begin
            overrideLevel_q <= wd[7:4];
            steerWritten_q  <= wd[3:0];
         end
         if (wrLow & (regIdx == `WSD_IDX_IRQMASK)) begin
            irqMask_q <= wd[1:0];
         end
      end
   end

   // ==========================================================
   // steer enables: direct in async mode, loaded at load point in sync mode
   always @(posedge clk_sys) begin
      if (reset) begin
         steerActive_q <= 4'h0;
      end else if (mode_q != `WSD_MODE_SSTEER) begin
         steerActive_q <= steerWritten_q;
      end else if (loadReq_q & dataRise) begin
         steerActive_q <= steerWritten_q; // RULE4
      end
   end

   // ==========================================================
   // shutdown hold until the first input rising edge after clearing
   always @(posedge clk_sys) begin
      if (reset) begin
         holdShut_q    <= 1'b0;
         effShutPrev_q <= 1'b0;
      end else begin
         effShutPrev_q <= effShut;
         if (shutdown_q) begin
            holdShut_q <= 1'b1;
         end else if (dataRise) begin
            holdShut_q <= 1'b0; // RULE7
         end
      end
   end

   // ==========================================================
   // interrupt flags: bit0 shutdown entered, bit1 output resumed; write one clears
   wire [1:0]  irqEvent = {effShutPrev_q & ~effShut, effShut & ~effShutPrev_q};
   wire [1:0]  irqClr   = (wrLow & (regIdx == `WSD_IDX_IRQSTAT)) ? wd[1:0] : 2'h0;
   always @(posedge clk_sys) begin
      if (reset) begin
         irqStatus_q <= 2'h0;
         irq_q       <= 1'b0;
      end else begin
         irqStatus_q <= irqEvent | (irqStatus_q & ~irqClr);
         irq_q       <= |(irqStatus_q & irqMask_q);
      end
   end

   // ==========================================================
   // waveform per mode before polarity
   reg         ppPhase_q;
   reg  [3:0]  modeWave;
   always @(posedge clk_sys) begin
      if (reset) begin
         ppPhase_q <= 1'b0;
      end else if (dataRise) begin
         ppPhase_q <= ~ppPhase_q;
      end
   end

   // bridge and push-pull patterns, bit 0 is output a
   always @* begin
      case (mode_q)
         `WSD_MODE_HALFB: modeWave = {fallDrv, riseDrv, fallDrv, riseDrv};
         `WSD_MODE_FWDFB: modeWave = {riseDrv, 1'b0, 1'b0, 1'b1};
         `WSD_MODE_REVFB: modeWave = {1'b0, 1'b1, riseDrv, 1'b0};
         `WSD_MODE_PUSHP: modeWave = {riseDrv & ppPhase_q, riseDrv & ~ppPhase_q,
                                      riseDrv & ppPhase_q, riseDrv & ~ppPhase_q};
         default:         modeWave = {4{dataIn}};
      endcase
   end

   wire        steerMode = (mode_q[2:1] == 2'b00);
   wire [3:0]  nextLevel;
   wire [3:0]  nextOe;

   // ==========================================================
   // per-output selection of steering, override, shutdown
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : gOut
         wire [1:0] pairCode = ((g % 2) == 1) ? pairBdLevel_q : pairAcLevel_q;
         wire [1:0] sdPick   = sdLevel(pairCode, polarity_q[g]); // RULE9 RULE10
         wire       runLvl   = (steerMode & ~steerActive_q[g]) ?
                               overrideLevel_q[g] :                  // RULE2 RULE3
                               modeWave[g] ^ polarity_q[g];          // RULE1 RULE16
         assign nextOe[g]    = effShut ? sdPick[1] : enable_q;
         assign nextLevel[g] = effShut ? (sdPick[0] & sdPick[1]) :
                               (enable_q & runLvl);
      end
   endgenerate

   // registered pins
   always @(posedge clk_sys) begin
      if (reset) begin
         pinOut_q <= 4'h0;
         pinOe_q  <= 4'h0;
      end else begin
         pinOut_q <= nextLevel;
         pinOe_q  <= nextOe;
      end
   end

   // ==========================================================
   // read mux
   reg  [7:0]  rdByte;
   always @* begin
      case (regIdx)
         `WSD_IDX_CLKSEL:  rdByte = {7'h00, fastOscSelect_q};
         `WSD_IDX_INSEL:   rdByte = inSel_q;
         `WSD_IDX_DBRISE:  rdByte = {2'h0, dbRise_q};
         `WSD_IDX_DBFALL:  rdByte = {2'h0, dbFall_q};
         `WSD_IDX_CTRL0:   rdByte = {enable_q, loadReq_q, 3'h0, mode_q};
         `WSD_IDX_CTRL1:   rdByte = {2'h0, dataIn, 1'b0, polarity_q};
         `WSD_IDX_SDCTRL:  rdByte = {shutdown_q, restartEn_q, pairBdLevel_q,
                                     pairAcLevel_q, 2'h0}; // RULE5
         `WSD_IDX_SDSRC:   rdByte = sdEnable_q;
         `WSD_IDX_STEER:   rdByte = {overrideLevel_q, steerWritten_q};
         `WSD_IDX_IRQSTAT: rdByte = {6'h00, irqStatus_q};
         `WSD_IDX_IRQMASK: rdByte = {6'h00, irqMask_q};
         default:          rdByte = 8'h00;
      endcase
   end

   // one-cycle acknowledge, read data registered with it
   always @(posedge clk_sys) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= busReq;
         if (busReq & ~wb_we_i) begin
            wb_dat_o <= {24'h000000, rdByte};
         end
      end
   end

endmodule // wsd_generator

//--- dv/wsd_stage_model.sv
// power switching stage model seen by the generator's output pins
`timescale 1ns/1ps
module wsd_stage_model (
   // clock and gate drive pins
   input  wire logic       clk_sys,
   input  wire logic [3:0] pinOut_q,
   input  wire logic [3:0] pinOe_q,
   // commanded overcurrent trip
   input  wire logic       faultCmd,
   output logic [3:0]      pad,
   output logic            fault
);
   logic tog_q = 1'b0;
   // an undriven gate floats: show a level that changes every cycle
   always @(posedge clk_sys) tog_q <= ~tog_q;
   assign pad = (pinOut_q & pinOe_q) | ({4{tog_q}} & ~pinOe_q);
   // the current sense comparator only trips when a scenario asks
   assign fault = faultCmd;
endmodule // wsd_stage_model

//--- dv/wsd_checker_properties.sv
// bus, reset and clock select assertions for the generator
`timescale 1ns/1ps
module wsd_checker (
   // clock and reset
   input wire        clk_sys,
   input wire        reset,
   // wishbone slave
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [13:0] wb_adr_i,
   input wire [3:0]  wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   // outputs
   input wire [3:0]  pinOe_q,
   input wire        fastOscSelect_q,
   input wire        irq_q
);
   // ==========================================================
   // request decode
   wire        take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire [11:0] idx  = wb_adr_i[13:2];
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // ==========================================================
   // properties
   property p_ack_ans; take |=> wb_ack_o; endproperty
   a_ack_ans: assert property (p_ack_ans) else $error("request not acked");
   property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
   property p_ack_src; wb_ack_o |-> $past(take); endproperty
   a_ack_src: assert property (p_ack_src) else $error("ack without request");
   property p_hi_zero; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("read data upper bits set");
   property p_unmap;
      take && !wb_we_i && (idx < 12'h60c || idx > 12'h616) |=> wb_dat_o == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_clksel;
      take && wb_we_i && wb_sel_i[0] && idx == 12'h60c |=>
         fastOscSelect_q == $past(wb_dat_i[0]);
   endproperty
   a_clksel: assert property (p_clksel) else $error("clock select not updated");
   property p_rst; $fell(reset) |-> pinOe_q == 4'h0 && !irq_q && !wb_ack_o; endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
   property p_dhold; !wb_ack_o |-> $stable(wb_dat_o); endproperty
   a_dhold: assert property (p_dhold) else $error("read data moved between reads");
endmodule // wsd_checker

bind wsd_generator wsd_checker u_wsd_checker (.clk_sys(clk_sys), .reset(reset),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .pinOe_q(pinOe_q), .fastOscSelect_q(fastOscSelect_q), .irq_q(irq_q));

//--- dv/testbench.sv
// self-checking bench for the waveform steering and shutdown generator
`timescale 1ns/1ps
`include "wsd_consts.vh"
module testbench;
   logic        clk_sys = 0, reset = 1, cyc = 0, stb = 0, wen = 0, faultCmd = 0;
   logic [13:0] adr = 0;
   logic [3:0]  sel = 0;
   logic [31:0] wdat = 0;
   logic [17:0] dsrc = 0;
   logic [7:0]  src = 0, q;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o, fastOscSelect_q, irq_q, fault;
   logic [3:0]  pinOut_q, pinOe_q, pad;
   int          errors = 0, n_tests = 0;
   // ==========================================================
   // design, power stage and clock
   wsd_generator u_wsd_generator (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(wen), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dataSources(dsrc),
      .shutdownSources(src | {3'h0, fault, 4'h0}), .pinOut_q(pinOut_q),
      .pinOe_q(pinOe_q), .fastOscSelect_q(fastOscSelect_q), .irq_q(irq_q));
   wsd_stage_model u_wsd_stage_model (.clk_sys(clk_sys), .pinOut_q(pinOut_q),
      .pinOe_q(pinOe_q), .faultCmd(faultCmd), .pad(pad), .fault(fault));
   initial forever #4 clk_sys = ~clk_sys;
   // ==========================================================
   // report, compare, bus and wait helpers
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] s, input logic [11:0] ix,
                     input logic [7:0] d);
      int k;
      cyc <= 1;
      stb <= 1;
      wen <= w;
      sel <= s;
      adr <= {ix, 2'h0};
      wdat <= {24'h0, d};
      for (k = 0; k < 20; k++) begin
         @(posedge clk_sys);
         if (wb_ack_o === 1'b1) break;
      end
      q = wb_dat_o[7:0];
      cyc <= 0;
      stb <= 0;
      if (k == 20) begin
         errors++;
         summarize();
      end
      @(posedge clk_sys);
   endtask
   task automatic wr(input logic [11:0] ix, input logic [7:0] d);
      wb(1, 4'h1, ix, d);
   endtask
   task automatic rc(input logic [11:0] ix, input logic [7:0] e);
      wb(0, 4'h1, ix, 8'h0);
      chk(q, e);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wpad(input logic [3:0] e);
      int k;
      for (k = 0; k < 40 && pad !== e; k++) @(posedge clk_sys);
      chk({4'h0, pad}, {4'h0, e});
      if (pad !== e) summarize();
   endtask
   task automatic gap(input int f, input int s, input int n);
      int k;
      for (k = 0; k < 200 && pad[f] !== 1'b0; k++) @(posedge clk_sys);
      for (k = 0; k < 200 && pad[s] !== 1'b1; k++) @(posedge clk_sys);
      chk({7'h0, k >= n && k <= n + 1}, 8'h01);
      if (k >= 200) summarize();
   endtask
   // ==========================================================
   // scenarios
   task automatic t_regs;
      rc(`WSD_IDX_STEER, 8'h00);
      rc(`WSD_IDX_SDCTRL, 8'h14);
      wr(12'h617, 8'hff);
      rc(12'h617, 8'h00);
      wb(1, 4'he, `WSD_IDX_STEER, 8'hff);
      rc(`WSD_IDX_STEER, 8'h00);
      wr(`WSD_IDX_CLKSEL, 8'h01);
      chk({7'h0, fastOscSelect_q}, 8'h01);
      wr(`WSD_IDX_CLKSEL, 8'h00);
      $display("test regs done");
   endtask
   task automatic t_steer;
      wr(`WSD_IDX_DBRISE, 8'h00);
      wr(`WSD_IDX_DBFALL, 8'h00);
      wr(`WSD_IDX_CTRL1, 8'h05);
      wr(`WSD_IDX_STEER, 8'h0f);
      wr(`WSD_IDX_CTRL0, 8'h80);
      dsrc[0] <= 1;
      wpad(4'ha);
      rc(`WSD_IDX_CTRL1, 8'h25);
      dsrc[0] <= 0;
      wpad(4'h5);
      wr(`WSD_IDX_STEER, 8'ha0);
      wpad(4'ha);
      wr(`WSD_IDX_CTRL0, 8'h84);
      wpad(4'hf);
      $display("test steer done");
   endtask
   task automatic t_sync;
      wr(`WSD_IDX_CTRL1, 8'h00);
      wr(`WSD_IDX_CTRL0, 8'h81);
      wr(`WSD_IDX_STEER, 8'h0f);
      wr(`WSD_IDX_CTRL0, 8'hc1);
      dsrc[0] <= 1;
      wpad(4'hf);
      wr(`WSD_IDX_STEER, 8'h00);
      tick(20);
      chk({4'h0, pad}, 8'h0f);
      wr(`WSD_IDX_CTRL0, 8'hc1);
      dsrc[0] <= 0;
      tick(10);
      dsrc[0] <= 1;
      tick(10);
      chk({4'h0, pad}, 8'h00);
      dsrc[0] <= 0;
      $display("test sync done");
   endtask
   task automatic t_db;
      int i;
      int r;
      logic [3:0] p;
      wr(`WSD_IDX_CTRL0, 8'h84);
      wpad(4'ha);
      for (i = 0; i < 2; i++) begin
         r = i ? 0 : 63;
         wr(`WSD_IDX_DBRISE, 8'(r));
         wr(`WSD_IDX_DBFALL, 8'(63 - r));
         dsrc[0] <= 1;
         gap(1, 0, r);
         dsrc[0] <= 0;
         gap(0, 1, 63 - r);
      end
      // bridge and push-pull patterns with no rising dead band
      wr(`WSD_IDX_CTRL0, 8'h82);
      dsrc[0] <= 1;
      wpad(4'h9);
      wr(`WSD_IDX_CTRL0, 8'h83);
      wpad(4'h6);
      wr(`WSD_IDX_CTRL0, 8'h85);
      tick(8);
      p = pad;
      chk({7'h0, p == 4'h5 || p == 4'ha}, 8'h01);
      dsrc[0] <= 0;
      tick(8);
      dsrc[0] <= 1;
      tick(8);
      chk({4'h0, pad ^ p}, 8'h0f);
      dsrc[0] <= 0;
      tick(8);
      $display("test deadband done");
   endtask
   task automatic t_shut;
      int i;
      wr(`WSD_IDX_STEER, 8'h0f);
      wr(`WSD_IDX_CTRL0, 8'h80);
      wr(`WSD_IDX_SDCTRL, 8'h38);
      for (i = 0; i < 8; i++) begin
         if (i == 3) continue;
         wr(`WSD_IDX_SDSRC, 8'h1 << i);
         wr(`WSD_IDX_IRQMASK, {7'h0, ~i[0]});
         if (i == 4) faultCmd <= 1;
         else src[i] <= 1;
         tick(10);
         rc(`WSD_IDX_SDCTRL, 8'hb8);
         chk({pinOe_q, pad}, 8'hfa);
         chk({7'h0, irq_q}, {7'h0, ~i[0]});
         src <= 0;
         faultCmd <= 0;
         tick(10);
         rc(`WSD_IDX_SDCTRL, 8'hb8);
         wr(`WSD_IDX_IRQSTAT, 8'h01);
         tick(2);
         chk({7'h0, irq_q}, 8'h00);
         wr(`WSD_IDX_SDCTRL, 8'h38);
         tick(10);
         chk({pinOe_q, pad}, 8'hfa);
         dsrc[0] <= 1;
         wpad(4'hf);
         dsrc[0] <= 0;
      end
      wr(`WSD_IDX_SDSRC, 8'h01);
      wr(`WSD_IDX_SDCTRL, 8'h78);
      src[0] <= 1;
      tick(10);
      rc(`WSD_IDX_SDCTRL, 8'hf8);
      src[0] <= 0;
      tick(10);
      rc(`WSD_IDX_SDCTRL, 8'h78);
      $display("test shutdown done");
   endtask
   task automatic t_sw;
      int i;
      logic [7:0] cf[4] = '{8'hb8, 8'h84, 8'h90, 8'hac};
      logic [7:0] ex[4] = '{8'hfa, 8'ha2, 8'h51, 8'hf5};
      // a data rising edge ends the shutdown hold left by the last test
      dsrc[0] <= 1;
      tick(8);
      dsrc[0] <= 0;
      wr(`WSD_IDX_SDCTRL, 8'h00);
      wr(`WSD_IDX_CTRL0, 8'h00);
      wr(`WSD_IDX_CTRL1, 8'h03);
      tick(4);
      chk({4'h0, pinOe_q}, 8'h00);
      for (i = 0; i < 4; i++) begin
         wr(`WSD_IDX_SDCTRL, cf[i]);
         tick(4);
         chk({pinOe_q, pinOut_q & pinOe_q}, ex[i]);
      end
      wr(`WSD_IDX_SDCTRL, 8'h00);
      $display("test software shutdown done");
   endtask
   task automatic t_rst;
      wr(`WSD_IDX_DBRISE, 8'h2a);
      reset <= 1;
      tick(2);
      reset <= 0;
      tick(1);
      rc(`WSD_IDX_DBRISE, 8'h2a);
      rc(`WSD_IDX_STEER, 8'h00);
      $display("test reset done");
   endtask
   // main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      reset <= 0;
      @(posedge clk_sys);
      t_regs();
      t_steer();
      t_sync();
      t_db();
      t_shut();
      t_sw();
      t_rst();
      summarize();
   end
endmodule // testbench
